// ===== logic/audio_port_defines.svh
// constants for the codec audio serial port and clock tree
`ifndef AUDIO_PORT_DEFINES_SVH
`define AUDIO_PORT_DEFINES_SVH
`define Q_MIN      5'h02
`define Q_MAX      5'h11
`define PLL_P_RST  3'h1
`define PLL_K_RST  6'h08
`define PLL_R_RST  4'h1
`define PLL_P_WRAP 4'h8
`define PLL_DEN    12'h080
`define WL_16      2'h0
`define WL_20      2'h1
`define WL_24      2'h2
`define WL_32      2'h3
`define BITS_16    6'h10
`define BITS_20    6'h14
`define BITS_24    6'h18
`define BITS_32    6'h20
`define WIDE_FRAME 9'h040
`define I2S_DELAY  9'h001
`define RATE_MIN   3'h1
`endif

// ===== logic/audio_port_pkg.sv
// types shared by the audio serial port design
package audio_port_pkg;
	typedef enum logic [1:0] {FMT_I2S, FMT_DSP, FMT_RJ, FMT_LJ} fmt_e;
	typedef enum logic [1:0] {GP_LEVEL, GP_ADC_WCLK, GP_ALT_WCLK} gpio_sel_e;
	typedef enum logic {MST_IDLE, MST_RUN} mst_state_e;
endpackage : audio_port_pkg

// ===== logic/sample_fifo.sv
// sample fifo between the converter side and the serial port
`timescale 1ns/10ps
module sample_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_sys,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output      logic             in_ready,
	output      logic [WIDTH-1:0] out_data,
	output      logic             out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic [AW:0]      count_next;
	logic             empty_reg;
	logic             push;
	logic             pop;

	assign push = in_valid && in_ready;
	assign pop = out_ready && !empty_reg;
	assign out_valid = !empty_reg;
	assign out_data = mem[rd_ptr_reg];

	always_comb
	begin
		count_next = count_reg;
		if (push && !pop)
			count_next = count_reg + 1'b1;
		else if (pop && !push)
			count_next = count_reg - 1'b1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			in_ready   <= 1'b1;
			empty_reg  <= 1'b1;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			count_reg <= count_next;
			in_ready  <= (count_next != FULL_CNT);
			empty_reg <= (count_next == '0);
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end
endmodule : sample_fifo

// ===== logic/audio_port_clocking.sv
// codec audio serial port with reference clock generation
// Summary of operation
// - port frames data as I2S, DSP, right- or left-justified.
// - word length and bit-clock rate mode are configured separately.
// - a data word offset positions sample words inside the frame.
// - in slave mode bit clock and word clock are inputs only.
// - in master mode the port drives bit clock and word clock.
// - option floats serial data out whenever no valid data is sent.
// - option keeps master clocks running while the codec is powered down.
// - resync realigns converter timing when drift exceeds quarter sample.
// - soft-mute option silences channels during a resync.
// - codec clock comes from integer divider or PLL divider output.
// - integer divider input is master clock pin or bit clock pin.
// - integer divider ratio ranges from 2 to 17.
// - PLL reference is master clock pin or bit clock pin.
// - PLL pre-divider, multiplier, post-factor apply only once loaded.
// - ADC and DAC rates derive from reference by factors, dual optional.
// - alternate pin can output ADC word clock or alternate word clock.
`timescale 1ns/10ps
`include "audio_port_defines.svh"
module audio_port_clocking #(
	parameter int CODEC_PER_FS = 256,
	parameter int BCLK_HALF    = 2,
	parameter int MUTE_CYC     = 64,
	parameter int FIFO_DEPTH   = 32
) (
	input  wire logic                     clk_sys,
	input  wire logic                     nrst,
	input  wire audio_port_pkg::fmt_e     fmt,
	input  wire logic [1:0]               word_len,
	input  wire logic                     bclk_mode,
	input  wire logic [7:0]               word_offset,
	input  wire logic                     master_mode,
	input  wire logic                     dout_tristate_en,
	input  wire logic                     keep_clocks_pd,
	input  wire logic                     codec_pd,
	input  wire logic                     resync_en,
	input  wire logic                     soft_mute_en,
	input  wire logic                     clk_src_pll,
	input  wire logic                     div_in_bclk,
	input  wire logic [4:0]               q_ratio,
	input  wire logic                     pll_ref_bclk,
	input  wire logic [2:0]               pll_p,
	input  wire logic [5:0]               pll_k,
	input  wire logic [3:0]               pll_r,
	input  wire logic                     pll_load,
	input  wire logic [2:0]               adc_rate_factor,
	input  wire logic [2:0]               dac_rate_factor,
	input  wire logic                     adc_dual_rate,
	input  wire logic                     dac_dual_rate,
	input  wire audio_port_pkg::gpio_sel_e gpio_sel,
	input  wire logic                     gpio_level,
	input  wire logic                     mclk_pin,
	input  wire logic                     bclk_in,
	input  wire logic                     wclk_in,
	input  wire logic                     din,
	output      logic                     bclk_out,
	output      logic                     bclk_oe,
	output      logic                     wclk_out,
	output      logic                     wclk_oe,
	output      logic                     dout,
	output      logic                     dout_oe,
	output      logic                     gpio_out,
	input  wire logic [31:0]              adc_data,
	input  wire logic                     adc_valid,
	output      logic                     adc_ready,
	output      logic [31:0]              dac_data,
	output      logic                     dac_valid,
	output      logic                     dac_right,
	output      logic                     mute_active
);
	import audio_port_pkg::*;

	localparam logic [8:0]  FS_HALF = 9'(CODEC_PER_FS / 2);
	localparam logic [7:0]  BH_LIM  = 8'(BCLK_HALF - 1);
	localparam logic [15:0] MUTE_N  = 16'(MUTE_CYC);

	logic        mclk_d_reg, bclk_d_reg, wclk_d_reg;
	logic        mclk_rise, bclk_rise_in, bclk_fall_in;
	logic [4:0]  q_eff, div_cnt_reg;
	logic        div_src, int_tick;
	logic [2:0]  p_reg;
	logic [5:0]  k_reg;
	logic [3:0]  r_reg;
	logic [11:0] acc_reg, acc_sum, acc_lim;
	logic        pll_src, pll_tick, codec_tick_reg;
	logic [8:0]  fs_cnt_reg;
	logic        fs2x_tick;
	logic [3:0]  adc_cnt_reg, dac_cnt_reg, adc_lim, dac_lim;
	logic        adc_tick, dac_tick, adc_wclk_reg;
	logic [15:0] phase_reg, period_reg, drift_a, drift_b, drift;
	logic [15:0] mute_cnt_reg;
	logic        resync_go;
	logic        mst_en;
	mst_state_e  mst_state_reg;
	logic [7:0]  bh_cnt_reg;
	logic [9:0]  tog_reg;
	logic        mst_tog, mst_fall, mst_rise, wclk_next;
	logic [5:0]  wl;
	logic [8:0]  frame_bits, half_bits, fall_idx, slot_start, slot_len;
	logic [8:0]  off, pos_reg, pos_new;
	logic        ev_fall, ev_rise, wc_now, wc_prev, wc_edge, edge_rst;
	logic        frm_start, in_slot_new, load, ch_new, slot_reg, have_reg;
	logic [31:0] sh_reg, rx_reg, fifo_data, aligned;
	logic [5:0]  rx_cnt_reg;
	logic        fifo_valid, dsp;

	assign dsp = (fmt == FMT_DSP);

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			mclk_d_reg <= 1'b0;
			// idle level of the bit clock, no false edge after reset
			bclk_d_reg <= 1'b1;
			wclk_d_reg <= 1'b0;
		end
		else
		begin
			mclk_d_reg <= mclk_pin;
			bclk_d_reg <= bclk_in;
			wclk_d_reg <= wclk_in;
		end
	end
	assign mclk_rise = mclk_pin && !mclk_d_reg;
	assign bclk_rise_in = bclk_in && !bclk_d_reg;
	assign bclk_fall_in = !bclk_in && bclk_d_reg;

	// integer divider
	assign div_src = div_in_bclk ? bclk_rise_in : mclk_rise;
	always_comb
	begin
		q_eff = q_ratio;
		if (q_ratio < `Q_MIN)
			q_eff = `Q_MIN;
		else if (q_ratio > `Q_MAX)
			q_eff = `Q_MAX;
	end
	assign int_tick = div_src && (div_cnt_reg >= q_eff - 5'h01);
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
			div_cnt_reg <= '0;
		else if (int_tick)
			div_cnt_reg <= '0;
		else if (div_src)
			div_cnt_reg <= div_cnt_reg + 5'h01;
	end

	// pll: parameters take effect only on load
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			p_reg <= `PLL_P_RST;
			k_reg <= `PLL_K_RST;
			r_reg <= `PLL_R_RST;
		end
		else if (pll_load)
		begin
			p_reg <= pll_p;
			k_reg <= pll_k;
			r_reg <= pll_r;
		end
	end
	assign pll_src = pll_ref_bclk ? bclk_rise_in : mclk_rise;
	assign acc_sum = acc_reg + 12'(k_reg * r_reg);
	assign acc_lim = 12'((p_reg == 3'h0 ? `PLL_P_WRAP : {1'b0, p_reg})
		* `PLL_DEN);
	assign pll_tick = pll_src && (acc_sum >= acc_lim);
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
			acc_reg <= '0;
		else if (pll_tick)
			acc_reg <= acc_sum - acc_lim;
		else if (pll_src)
			acc_reg <= acc_sum;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
			codec_tick_reg <= 1'b0;
		else
			codec_tick_reg <= clk_src_pll ? pll_tick : int_tick;
	end

	// reference rate at twice fsref, then converter rates
	assign fs2x_tick = codec_tick_reg && (fs_cnt_reg == FS_HALF - 9'h001);
	assign adc_lim = adc_dual_rate ? {1'b0, adc_rate_factor}
		: {adc_rate_factor, 1'b0};
	assign dac_lim = dac_dual_rate ? {1'b0, dac_rate_factor}
		: {dac_rate_factor, 1'b0};
	assign adc_tick = fs2x_tick && (adc_cnt_reg + 4'h1 >= adc_lim);
	assign dac_tick = fs2x_tick && (dac_cnt_reg + 4'h1 >= dac_lim);
	always_ff @(posedge clk_sys)
	begin
		if (!nrst || resync_go)
		begin
			fs_cnt_reg  <= '0;
			adc_cnt_reg <= '0;
			dac_cnt_reg <= '0;
		end
		else
		begin
			if (fs2x_tick)
				fs_cnt_reg <= '0;
			else if (codec_tick_reg)
				fs_cnt_reg <= fs_cnt_reg + 9'h001;
			if (adc_tick)
				adc_cnt_reg <= '0;
			else if (fs2x_tick)
				adc_cnt_reg <= adc_cnt_reg + 4'h1;
			if (dac_tick)
				dac_cnt_reg <= '0;
			else if (fs2x_tick)
				dac_cnt_reg <= dac_cnt_reg + 4'h1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
			adc_wclk_reg <= 1'b0;
		else if (adc_tick)
			adc_wclk_reg <= 1'b1;
		else if (fs2x_tick)
			adc_wclk_reg <= 1'b0;
	end

	// frame geometry
	always_comb
	begin
		case (word_len)
			`WL_16: wl = `BITS_16;
			`WL_20: wl = `BITS_20;
			`WL_24: wl = `BITS_24;
			default: wl = `BITS_32;
		endcase
	end
	assign frame_bits = bclk_mode ? `WIDE_FRAME : {2'h0, wl, 1'b0};
	assign half_bits = frame_bits >> 1;
	assign off = {1'b0, word_offset};
	assign slot_len = dsp ? {2'h0, wl, 1'b0} : {3'h0, wl};
	always_comb
	begin
		case (fmt)
			FMT_I2S: slot_start = `I2S_DELAY + off;
			FMT_DSP: slot_start = `I2S_DELAY + off;
			FMT_RJ:  slot_start = half_bits - {3'h0, wl} + off;
			default: slot_start = off;
		endcase
	end

	// master bit and word clock generator
	assign mst_en = master_mode && (!codec_pd || keep_clocks_pd);
	assign mst_tog = (mst_state_reg == MST_RUN) && (bh_cnt_reg == BH_LIM);
	assign mst_fall = mst_tog && bclk_out;
	assign mst_rise = mst_tog && !bclk_out;
	assign fall_idx = tog_reg[9:1];
	always_comb
	begin
		wclk_next = wclk_out;
		if (mst_fall)
		begin
			if (dsp)
				wclk_next = (fall_idx == 9'h000);
			else if (fall_idx == 9'h000)
				wclk_next = (fmt != FMT_I2S);
			else if (fall_idx == half_bits)
				wclk_next = (fmt == FMT_I2S);
		end
	end
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			mst_state_reg <= MST_IDLE;
			bh_cnt_reg    <= '0;
			tog_reg       <= '0;
			bclk_out      <= 1'b1;
			wclk_out      <= 1'b0;
		end
		else
		begin
			case (mst_state_reg)
				MST_IDLE:
				begin
					bh_cnt_reg <= '0;
					tog_reg    <= '0;
					if (dac_tick && mst_en)
						mst_state_reg <= MST_RUN;
				end
				MST_RUN:
				begin
					bh_cnt_reg <= mst_tog ? 8'h00 : bh_cnt_reg + 8'h01;
					if (mst_tog)
					begin
						bclk_out <= !bclk_out;
						tog_reg  <= tog_reg + 10'h001;
						if (tog_reg == {frame_bits, 1'b0} - 10'h001)
							mst_state_reg <= MST_IDLE;
					end
				end
				default: mst_state_reg <= MST_IDLE;
			endcase
			wclk_out <= wclk_next;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			bclk_oe <= 1'b0;
			wclk_oe <= 1'b0;
		end
		else
		begin
			bclk_oe <= mst_en;
			wclk_oe <= mst_en;
		end
	end

	// common bit position tracking for both roles
	assign ev_fall = master_mode ? mst_fall : bclk_fall_in;
	assign ev_rise = master_mode ? mst_rise : bclk_rise_in;
	assign wc_now = master_mode ? wclk_next : wclk_in;
	assign wc_prev = master_mode ? wclk_out : wclk_d_reg;
	assign wc_edge = wc_now != wc_prev;
	assign edge_rst = ev_fall && wc_edge && (!dsp || wc_now);
	assign frm_start = edge_rst && (dsp || (wc_now == (fmt != FMT_I2S)));
	assign pos_new = edge_rst ? 9'h000 : pos_reg + 9'h001;
	assign in_slot_new = (pos_new >= slot_start)
		&& (pos_new < slot_start + slot_len);
	assign load = in_slot_new && ((pos_new == slot_start)
		|| (dsp && pos_new == slot_start + {3'h0, wl}));
	assign ch_new = dsp ? (pos_new >= slot_start + {3'h0, wl})
		: ((fmt == FMT_I2S) ? wc_now : !wc_now);
	assign aligned = fifo_data << (6'h20 - wl);

	sample_fifo #(
		.WIDTH (32),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.nrst      (nrst),
		.in_data   (adc_data),
		.in_valid  (adc_valid),
		.in_ready  (adc_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (ev_fall && load)
	);

	// transmit path
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			pos_reg  <= '0;
			slot_reg <= 1'b0;
			have_reg <= 1'b0;
			sh_reg   <= '0;
			dout     <= 1'b0;
			dout_oe  <= 1'b0;
		end
		else if (ev_fall)
		begin
			pos_reg  <= pos_new;
			slot_reg <= in_slot_new;
			if (load)
			begin
				have_reg <= fifo_valid;
				sh_reg   <= (fifo_valid && !mute_active) ? aligned : '0;
				dout     <= fifo_valid && !mute_active && aligned[31];
				dout_oe  <= !dout_tristate_en || fifo_valid;
			end
			else
			begin
				sh_reg  <= sh_reg << 1;
				dout    <= in_slot_new && sh_reg[30];
				dout_oe <= !dout_tristate_en || (in_slot_new && have_reg);
			end
		end
	end

	// receive path
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			rx_reg     <= '0;
			rx_cnt_reg <= '0;
			dac_data   <= '0;
			dac_valid  <= 1'b0;
			dac_right  <= 1'b0;
		end
		else
		begin
			dac_valid <= 1'b0;
			if (ev_fall && load)
			begin
				// clear so the word arrives right-justified
				rx_reg     <= '0;
				rx_cnt_reg <= '0;
			end
			else if (ev_rise && slot_reg)
			begin
				rx_reg     <= {rx_reg[30:0], din};
				rx_cnt_reg <= rx_cnt_reg + 6'h01;
				if (rx_cnt_reg == wl - 6'h01)
				begin
					dac_data  <= mute_active ? '0 : {rx_reg[30:0], din};
					dac_valid <= 1'b1;
					dac_right <= dsp
						? (pos_reg >= slot_start + {3'h0, wl}) : ch_new;
				end
			end
		end
	end

	// resync: phase of incoming frame against dac sample tick
	assign drift_a = phase_reg;
	assign drift_b = period_reg - phase_reg;
	assign drift = (drift_a < drift_b) ? drift_a : drift_b;
	assign resync_go = resync_en && !master_mode && frm_start
		&& (drift > (period_reg >> 2));
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			phase_reg  <= '0;
			period_reg <= '0;
		end
		else if (resync_go)
			phase_reg <= '0;
		else if (dac_tick)
		begin
			period_reg <= phase_reg + 16'h0001;
			phase_reg  <= '0;
		end
		else if (phase_reg != 16'hFFFF)
			phase_reg <= phase_reg + 16'h0001;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
			mute_cnt_reg <= '0;
		else if (resync_go && soft_mute_en)
			mute_cnt_reg <= MUTE_N;
		else if (mute_cnt_reg != '0)
			mute_cnt_reg <= mute_cnt_reg - 16'h0001;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			mute_active <= 1'b0;
			gpio_out    <= 1'b0;
		end
		else
		begin
			mute_active <= (resync_go && soft_mute_en)
				|| (mute_cnt_reg > 16'h0001);
			case (gpio_sel)
				GP_ADC_WCLK: gpio_out <= adc_wclk_reg;
				GP_ALT_WCLK: gpio_out <= wc_now;
				default:     gpio_out <= gpio_level;
			endcase
		end
	end

	sequence s_resync_muted;
		mute_active [*3];
	endsequence

	chk_slave_inputs: assert property (@(posedge clk_sys) disable iff (!nrst)
		!master_mode |=> !bclk_oe && !wclk_oe)
		else $error("slave mode drives a clock pin");
	chk_master_drive: assert property (@(posedge clk_sys) disable iff (!nrst)
		master_mode && !codec_pd |=> bclk_oe && wclk_oe)
		else $error("master mode does not drive clocks");
	chk_pd_clock_stop: assert property (@(posedge clk_sys) disable iff (!nrst)
		codec_pd && !keep_clocks_pd |=> !bclk_oe && !wclk_oe)
		else $error("clocks driven in power down");
	chk_dout_float: assert property (@(posedge clk_sys) disable iff (!nrst)
		$past(dout_tristate_en) && $changed(pos_reg) && !slot_reg |-> !dout_oe)
		else $error("data out driven outside a slot");
	chk_q_range: assert property (@(posedge clk_sys) disable iff (!nrst)
		q_eff >= `Q_MIN && q_eff <= `Q_MAX && div_cnt_reg < `Q_MAX)
		else $error("integer divider ratio out of range");
	chk_pll_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
		!pll_load |=> $stable(p_reg) && $stable(k_reg) && $stable(r_reg))
		else $error("pll setting changed without load");
	chk_src_select: assert property (@(posedge clk_sys) disable iff (!nrst)
		!clk_src_pll && !int_tick |=> !codec_tick_reg)
		else $error("codec clock not from selected source");
	chk_resync_mute: assert property (@(posedge clk_sys) disable iff (!nrst)
		resync_go && soft_mute_en |=> s_resync_muted)
		else $error("channels not muted during resync");
	chk_resync_align: assert property (@(posedge clk_sys) disable iff (!nrst)
		resync_go |=> phase_reg == '0 && fs_cnt_reg == '0)
		else $error("resync did not realign");
	chk_wclk_on_fall: assert property (@(posedge clk_sys) disable iff (!nrst)
		master_mode && $changed(wclk_out) |-> $fell(bclk_out))
		else $error("word clock edge not on bit clock fall");
endmodule : audio_port_clocking

// ===== tb/audio_host_model.sv
// audio host partner: makes slave clocks, sends and captures serial words
`timescale 1ns/10ps
module audio_host_model #(
	parameter int HALF = 4
) (
	input  wire logic                 clk_sys,
	input  wire logic                 run,
	input  wire audio_port_pkg::fmt_e fmt,
	input  wire logic [15:0]          tx_left,
	input  wire logic [15:0]          tx_right,
	input  wire logic                 dout,
	output      logic                 bclk_in,
	output      logic                 wclk_in,
	output      logic                 din,
	output      logic [15:0]          rx_left,
	output      logic [15:0]          rx_right,
	output      logic [15:0]          n_frames
);
	import audio_port_pkg::*;
	logic [15:0] rx_word;

	initial
	begin
		bclk_in = 1'b1;
		wclk_in = 1'b1;
		din = 1'b0;
		n_frames = 16'h0000;
	end

	// one 64-bit frame, 16-bit words, msb first
	task automatic frame();
		int b;
		logic ch;
		for (int i = 0; i < 64; i++)
		begin
			ch = (i >= 32);
			b = i % 32 - ((fmt == FMT_RJ) ? 16 : (fmt == FMT_LJ) ? 0 : 1);
			if (fmt == FMT_DSP)
			begin
				ch = (i >= 17);
				b = (i == 0 || i > 32) ? -1 : (i - 1) % 16;
			end
			// wclk moves only with a bclk fall
			wclk_in <= (fmt == FMT_DSP) ? (i == 0) : ((fmt == FMT_I2S) == ch);
			bclk_in <= 1'b0;
			if (b >= 0 && b < 16)
				din <= ch ? tx_right[15-b] : tx_left[15-b];
			else
				din <= ~din;
			repeat (HALF) @(posedge clk_sys);
			bclk_in <= 1'b1;
			if (b >= 0 && b < 16)
				rx_word[15-b] = dout;
			if (b == 15 && ch)
				rx_right <= rx_word;
			if (b == 15 && !ch)
				rx_left <= rx_word;
			repeat (HALF) @(posedge clk_sys);
		end
		n_frames <= n_frames + 16'h0001;
	endtask : frame

	// bclk stands still between frames, idle data keeps changing
	always
	begin
		repeat (2) @(posedge clk_sys);
		if (run)
			frame();
		else
			din <= ~din;
	end
endmodule : audio_host_model

// ===== tb/codec_audio_port_clocking_bench.sv
// testbench for the codec audio serial port and clock tree
`timescale 1ns/10ps
module codec_audio_port_clocking_bench;
	import audio_port_pkg::*;
	logic clk_sys = 1'b0, nrst = 1'b0, mclk_pin = 1'b0, run = 1'b0;
	fmt_e fmt = FMT_I2S;
	gpio_sel_e gpio_sel = GP_LEVEL;
	logic [1:0] word_len = 2'h0;
	logic [7:0] word_offset = 8'h00;
	logic [4:0] q_ratio = 5'h02;
	logic [2:0] pll_p = 3'h1, adc_rate_factor = 3'h6, dac_rate_factor = 3'h6;
	logic [5:0] pll_k = 6'h08;
	logic [3:0] pll_r = 4'h1;
	logic bclk_mode = 1'b1, master_mode = 1'b0, dout_tristate_en = 1'b1;
	logic keep_clocks_pd = 1'b0, codec_pd = 1'b0, resync_en = 1'b0;
	logic soft_mute_en = 1'b0, clk_src_pll = 1'b0, div_in_bclk = 1'b0;
	logic pll_ref_bclk = 1'b0, pll_load = 1'b0, gpio_level = 1'b0;
	logic adc_dual_rate = 1'b0, dac_dual_rate = 1'b0, adc_valid = 1'b0;
	logic [31:0] adc_data = 32'h0, dac_data, got_l, got_r;
	logic [15:0] tx_left = 16'h0, tx_right = 16'h0, rx_left, rx_right;
	logic [15:0] n_frames;
	logic bclk_in, wclk_in, din, bclk_out, bclk_oe, wclk_out, wclk_oe;
	logic dout, dout_oe, gpio_out, adc_ready, dac_valid, dac_right;
	logic mute_active, seen_oe = 1'b0, seen_mute = 1'b0;
	int n_mismatch = 0, n_checks = 0;

	audio_port_clocking #(.CODEC_PER_FS(8), .MUTE_CYC(4)) dut_u (
		.clk_sys, .nrst, .fmt, .word_len, .bclk_mode, .word_offset,
		.master_mode, .dout_tristate_en, .keep_clocks_pd, .codec_pd,
		.resync_en, .soft_mute_en, .clk_src_pll, .div_in_bclk, .q_ratio,
		.pll_ref_bclk, .pll_p, .pll_k, .pll_r, .pll_load, .adc_rate_factor,
		.dac_rate_factor, .adc_dual_rate, .dac_dual_rate, .gpio_sel,
		.gpio_level, .mclk_pin, .bclk_in, .wclk_in, .din, .bclk_out,
		.bclk_oe, .wclk_out, .wclk_oe, .dout, .dout_oe, .gpio_out,
		.adc_data, .adc_valid, .adc_ready, .dac_data, .dac_valid,
		.dac_right, .mute_active);
	audio_host_model host_u (.clk_sys, .run, .fmt, .tx_left, .tx_right,
		.dout, .bclk_in, .wclk_in, .din, .rx_left, .rx_right, .n_frames);

	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) mclk_pin <= ~mclk_pin;
	always @(posedge clk_sys)
	begin
		if (dac_valid === 1'b1 && dac_right === 1'b1)
			got_r <= dac_data;
		if (dac_valid === 1'b1 && dac_right === 1'b0)
			got_l <= dac_data;
		if (dout_oe === 1'b1)
			seen_oe <= 1'b1;
		if (mute_active === 1'b1)
			seen_mute <= 1'b1;
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic give_up();
		n_mismatch++;
		complete_run();
	endtask : give_up

	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : tick

	task automatic frames(input int n);
		int f0;
		f0 = n_frames + n;
		for (int t = 0; n_frames != 16'(f0); t++)
		begin
			if (t > 1000 * n)
				give_up();
			tick(1);
		end
	endtask : frames

	// clocks and bclk falls from one wclk fall to the next
	task automatic wclk_fall(output int per, output int falls);
		logic pb;
		logic pw;
		falls = 0;
		for (per = 1; per <= 9000; per++)
		begin
			pb = bclk_out;
			pw = wclk_out;
			tick(1);
			if (pb === 1'b1 && bclk_out === 1'b0)
				falls++;
			if (pw !== wclk_out)
				check(32'(pb & ~bclk_out), 32'h1);
			if (pw === 1'b1 && wclk_out === 1'b0)
				return;
		end
		give_up();
	endtask : wclk_fall

	task automatic period_is(input int ep, input int ef);
		int p;
		int f;
		repeat (3) wclk_fall(p, f);
		check(32'(p), 32'(ep));
		check(32'(f), 32'(ef));
	endtask : period_is

	task automatic t_master();
		@(posedge clk_sys);
		master_mode <= 1'b1;
		bclk_mode <= 1'b0;
		tick(3);
		check(32'({bclk_oe, wclk_oe}), 32'h3);
		period_is(192, 32);
		q_ratio <= 5'h01;
		period_is(192, 32);
		q_ratio <= 5'h11;
		bclk_mode <= 1'b1;
		period_is(1632, 64);
		word_len <= 2'h2;
		bclk_mode <= 1'b0;
		period_is(1632, 48);
		word_len <= 2'h0;
		clk_src_pll <= 1'b1;
		period_is(1536, 32);
		pll_k <= 6'h10;
		period_is(1536, 32);
		@(posedge clk_sys);
		pll_load <= 1'b1;
		@(posedge clk_sys);
		pll_load <= 1'b0;
		period_is(768, 32);
		codec_pd <= 1'b1;
		tick(3);
		check(32'({bclk_oe, wclk_oe}), 32'h0);
		keep_clocks_pd <= 1'b1;
		gpio_level <= 1'b1;
		tick(3);
		check(32'({bclk_oe, wclk_oe}), 32'h3);
		check(32'(gpio_out), 32'h1);
		codec_pd <= 1'b0;
		master_mode <= 1'b0;
		bclk_mode <= 1'b1;
	endtask : t_master

	task automatic t_formats();
		fmt_e f;
		f = FMT_DSP;
		@(posedge clk_sys);
		run <= 1'b1;
		tick(3);
		check(32'({bclk_oe, wclk_oe}), 32'h0);
		repeat (4)
		begin
			@(posedge clk_sys);
			fmt <= f;
			tx_left <= 16'hA5C3 ^ 16'(f);
			tx_right <= 16'h3C5A + 16'(f);
			frames(3);
			check(got_l, {16'h0000, tx_left});
			check(got_r, {16'h0000, tx_right});
			f = f.next();
		end
		check(32'(seen_oe), 32'h0);
	endtask : t_formats

	task automatic t_fifo();
		int n;
		n = 0;
		@(posedge clk_sys);
		run <= 1'b0;
		seen_oe <= 1'b0;
		adc_valid <= 1'b1;
		adc_data <= 32'h0000B000;
		repeat (40)
		begin
			@(posedge clk_sys);
			if (adc_ready === 1'b1)
			begin
				n++;
				adc_data <= 32'h0000B000 + 32'(n);
			end
		end
		adc_valid <= 1'b0;
		check(32'(n), 32'h20);
		check(32'(adc_ready), 32'h0);
		run <= 1'b1;
		for (int k = 0; k < 16; k++)
		begin
			frames(1);
			check(32'(rx_left), 32'hB000 + 32'(2 * k));
			check(32'(rx_right), 32'hB001 + 32'(2 * k));
		end
		check(32'({seen_oe, adc_ready}), 32'h3);
		check(32'(seen_mute), 32'h0);
		@(posedge clk_sys);
		resync_en <= 1'b1;
		soft_mute_en <= 1'b1;
		frames(4);
		check(32'(seen_mute), 32'h1);
		@(posedge clk_sys);
		resync_en <= 1'b0;
		soft_mute_en <= 1'b0;
		run <= 1'b0;
	endtask : t_fifo

	initial
	begin
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
		tick(1);
		check(32'({bclk_out, bclk_oe, wclk_out, wclk_oe, dout_oe, dac_valid,
			adc_ready, mute_active}), 32'h82);
		t_master();
		t_formats();
		t_fifo();
		complete_run();
	end
endmodule : codec_audio_port_clocking_bench
